// ### rtl/tcs_map.vh
// Purpose: Constants for the per-channel transmit clock select block
// Assumes: Four channels; channel n decodes at byte address n * 0x1000
// Notes: Tags below mark the logic that keeps rules RL1 to RL9
// Function
// RL1 - Bit 7 rising inserts one line violation
// RL2 - Bit 6: 0 selects E1, 1 selects T1
// RL3 - Bit 5 aligns framers to 8 kHz reference
// RL4 - Channel 0 bit 5 governs all four channels
// RL5 - Alignment works only under PLL timing source
// RL6 - Lost line clock falls back to PLL clock
// RL7 - Bit 4 enables protection, resets to one
// RL8 - Clock loss status sets only when protected
// RL9 - Source field: 00/11 line, 01 ext, 10 PLL
// RL10 - Software writes zero to reserved bits
`ifndef TCS_MAP_VH
`define TCS_MAP_VH

// Channel count and address slicing
`define TCS_NCH 4
`define TCS_CH_W 8
`define TCS_CH_LSB 12
`define TCS_CH_MSB 13
`define TCS_OFF_MSB 11
`define TCS_HI_LSB 14

// Register offsets inside one channel window
`define TCS_CSR_OFF 12'h100
`define TCS_BLOCK_INTERRUPT_STATUS_OFF 12'hb00
`define TCS_MASK_OFF 12'hc00
`define TCS_STATE_OFF 12'hc04

// Clock select register fields and reset value
`define TCS_CSR_RST 8'h11
`define TCS_LCV_BIT 7
`define TCS_T1_BIT 6
`define TCS_SYNC_BIT 5
`define TCS_PROT_BIT 4
`define TCS_SRC_LSB 0

// Status and mask field for clock loss
`define TCS_LOSS_BIT 5

// Transmit timing source codes
`define TCS_SRC_LINE 2'h0
`define TCS_SRC_EXT 2'h1
`define TCS_SRC_PLL 2'h2
`define TCS_SRC_LINE2 2'h3

// AHB transfer type bit that marks an active transfer
`define TCS_HTRANS_ACT 1

`endif

// ### rtl/tcs_chan.v
// Purpose: One channel of transmit timing source selection
// Assumes: Clock loss flag arrives synchronous to i_clk
// Notes: All outputs are registered
`timescale 1ns/1ns
`include "tcs_map.vh"

module tcs_chan (
   input wire i_clk,
   input wire i_sys_rst,
   input wire [1:0] i_src_sel,
   input wire i_protect,
   input wire i_sync_all,
   input wire i_clk_lost,
   output reg [1:0] o_src,
   output reg o_align,
   output reg o_fallback,
   output reg o_serclk_oe,
   output reg o_loss_evt
);
   localparam [3:0] ST_LINE = 4'h1;
   localparam [3:0] ST_EXT = 4'h2;
   localparam [3:0] ST_PLL = 4'h4;
   localparam [3:0] ST_HOLD = 4'h8;

   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg lost_q_r;
   wire loop_sel;

   assign loop_sel = (i_src_sel == `TCS_SRC_LINE) || (i_src_sel == `TCS_SRC_LINE2); // RL9

   // Source state follows the field; hold is the protected fallback
   always @* begin
      state_nxt = ST_EXT;
      case (state_r)
         ST_LINE, ST_EXT, ST_PLL, ST_HOLD: begin
            if (loop_sel && i_protect && i_clk_lost)
               state_nxt = ST_HOLD; // RL6
            else if (loop_sel)
               state_nxt = ST_LINE; // RL9
            else if (i_src_sel == `TCS_SRC_PLL)
               state_nxt = ST_PLL;
            else
               state_nxt = ST_EXT;
         end
         default: state_nxt = ST_EXT;
      endcase
   end

   // Registered outputs; all but the loss event derive from the next state
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         state_r <= ST_EXT;
         lost_q_r <= 1'b0;
         o_src <= `TCS_SRC_EXT;
         o_align <= 1'b0;
         o_fallback <= 1'b0;
         o_serclk_oe <= 1'b0;
         o_loss_evt <= 1'b0;
      end else begin
         state_r <= state_nxt;
         lost_q_r <= i_clk_lost;
         o_src <= state_nxt[0] ? `TCS_SRC_LINE : (state_nxt[1] ? `TCS_SRC_EXT : `TCS_SRC_PLL); // RL6
         o_align <= i_sync_all & (state_nxt[2] | state_nxt[3]); // RL5
         o_fallback <= state_nxt[3];
         o_serclk_oe <= ~state_nxt[1]; // Serial clock pin drives out unless external
         o_loss_evt <= i_protect & i_clk_lost & ~lost_q_r; // RL8
      end
   end
endmodule // tcs_chan

// ### rtl/tcs_top.v
// Purpose: Four-channel transmit clock select registers on AHB-Lite
// Assumes: Single word transfers; inputs synchronous to i_clk
// Notes: Zero wait state slave; reads see same-cycle writes
`timescale 1ns/1ns
`include "tcs_map.vh"

module tcs_top (
   input wire i_clk,
   input wire i_sys_rst,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   input wire [3:0] i_rec_clk_lost,
   output wire [7:0] o_tx_src,
   output reg [3:0] o_t1_mode,
   output wire [3:0] o_frame_align,
   output reg [3:0] o_lcv_inject,
   output wire [3:0] o_serclk_oe,
   output wire [3:0] o_clk_fallback,
   output reg o_irq
);
   // Register storage, flattened per channel
   reg [31:0] csr_r;
   reg [31:0] csr_nxt;
   reg [3:0] stat_r;
   reg [3:0] stat_nxt;
   reg [3:0] mask_r;
   reg [3:0] mask_nxt;
   reg [3:0] lcv_nxt;

   // Data phase bookkeeping
   reg wr_r;
   reg [1:0] wr_ch_r;
   reg [11:0] wr_off_r;

   // Address phase decode
   wire acc;
   wire hi_zero;
   wire [1:0] a_ch;
   wire [11:0] a_off;
   reg [31:0] rd_nxt;

   // Per-channel results from the timing source logic
   wire [3:0] loss_evt;
   wire sync_all;

   assign acc = i_hsel & i_htrans[`TCS_HTRANS_ACT] & i_hready;
   assign hi_zero = ~|i_haddr[31:`TCS_HI_LSB];
   assign a_ch = i_haddr[`TCS_CH_MSB:`TCS_CH_LSB];
   assign a_off = i_haddr[`TCS_OFF_MSB:0];

   // Only channel 0 holds the alignment switch for the whole device
   assign sync_all = csr_r[`TCS_SYNC_BIT]; // RL4

   // Capture the address phase; hsize is ignored since only words are used
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         wr_r <= 1'b0;
         wr_ch_r <= 2'h0;
         wr_off_r <= 12'h000;
      end else begin
         wr_r <= acc & i_hwrite & hi_zero;
         wr_ch_r <= a_ch;
         wr_off_r <= a_off;
      end
   end

   // Next register values: writes land in the data phase
   always @* begin
      csr_nxt = csr_r;
      mask_nxt = mask_r;
      lcv_nxt = 4'h0;
      stat_nxt = stat_r | loss_evt; // RL8
      if (wr_r) begin
         case (wr_off_r)
            `TCS_CSR_OFF: begin
               csr_nxt[{wr_ch_r, 3'b000} +: 8] = i_hwdata[7:0]; // RL2
               lcv_nxt[wr_ch_r] = i_hwdata[`TCS_LCV_BIT] &
                  ~csr_r[{wr_ch_r, 3'b000} + `TCS_LCV_BIT]; // RL1
            end
            `TCS_BLOCK_INTERRUPT_STATUS_OFF: begin
               // A loss arriving with the clear still sets the flag
               stat_nxt[wr_ch_r] = (stat_r[wr_ch_r] & ~i_hwdata[`TCS_LOSS_BIT]) | loss_evt[wr_ch_r];
            end
            `TCS_MASK_OFF: begin
               mask_nxt[wr_ch_r] = i_hwdata[`TCS_LOSS_BIT];
            end
            default: begin
               csr_nxt = csr_r;
            end
         endcase
      end
   end

   // Register state, reset to documented defaults
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         csr_r <= {`TCS_NCH{`TCS_CSR_RST}}; // RL7
         stat_r <= 4'h0;
         mask_r <= 4'h0;
         o_lcv_inject <= 4'h0;
      end else begin
         csr_r <= csr_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         o_lcv_inject <= lcv_nxt; // RL1
      end
   end

   // Read mux looks at next values so a write is visible at once
   always @* begin
      rd_nxt = 32'h0000_0000;
      if (hi_zero) begin
         case (a_off)
            `TCS_CSR_OFF: rd_nxt[7:0] = csr_nxt[{a_ch, 3'b000} +: 8];
            `TCS_BLOCK_INTERRUPT_STATUS_OFF: rd_nxt[`TCS_LOSS_BIT] = stat_nxt[a_ch];
            `TCS_MASK_OFF: rd_nxt[`TCS_LOSS_BIT] = mask_nxt[a_ch];
            `TCS_STATE_OFF: rd_nxt[3:0] = {o_clk_fallback[a_ch], o_frame_align[a_ch],
               o_tx_src[{a_ch, 1'b1}], o_tx_src[{a_ch, 1'b0}]};
            default: rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   // Bus answer: never waits, always OKAY, unmapped reads zero
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_hrdata <= 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end else begin
         o_hrdata <= (acc & ~i_hwrite) ? rd_nxt : 32'h0000_0000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
      end
   end

   // Mode and interrupt outputs, each from a flop
   always @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_t1_mode <= 4'h0;
         o_irq <= 1'b0;
      end else begin
         o_t1_mode <= {csr_nxt[3 * `TCS_CH_W + `TCS_T1_BIT], csr_nxt[2 * `TCS_CH_W + `TCS_T1_BIT],
            csr_nxt[`TCS_CH_W + `TCS_T1_BIT], csr_nxt[`TCS_T1_BIT]}; // RL2
         o_irq <= |(stat_nxt & mask_nxt);
      end
   end

   // One timing source selector per channel
   genvar g;
   generate
      for (g = 0; g < `TCS_NCH; g = g + 1) begin : g_ch
         tcs_chan u_chan (
            .i_clk(i_clk),
            .i_sys_rst(i_sys_rst),
            .i_src_sel(csr_r[g*`TCS_CH_W + `TCS_SRC_LSB +: 2]), // RL9
            .i_protect(csr_r[g*`TCS_CH_W + `TCS_PROT_BIT]), // RL7
            .i_sync_all(sync_all), // RL3
            .i_clk_lost(i_rec_clk_lost[g]),
            .o_src(o_tx_src[g*2 +: 2]),
            .o_align(o_frame_align[g]),
            .o_fallback(o_clk_fallback[g]),
            .o_serclk_oe(o_serclk_oe[g]),
            .o_loss_evt(loss_evt[g])
         );
      end
   endgenerate
endmodule // tcs_top

// ### tb/tcs_properties.sv
// Purpose: Port assertions for the clock select block
// Assumes: One clock, synchronous reset
// Notes: Channels 0 and 1 stand for the rest
`timescale 1ns/1ns
module tcs_props (
   input wire i_clk,
   input wire i_sys_rst,
   input wire o_hreadyout,
   input wire o_hresp,
   input wire [3:0] i_rec_clk_lost,
   input wire [7:0] o_tx_src,
   input wire [3:0] o_frame_align,
   input wire [3:0] o_lcv_inject,
   input wire [3:0] o_serclk_oe,
   input wire [3:0] o_clk_fallback
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   // Zero wait slave never stalls
   ready_always_a: assert property (o_hreadyout) else $error("slave stalled");
   resp_okay_a: assert property (!o_hresp) else $error("slave answered error");
   // Pulses of different channels may follow each other; one channel never pulses in two cycles running
   inject_one_cycle_a: assert property (|o_lcv_inject |=> (o_lcv_inject & $past(o_lcv_inject)) == 4'h0)
      else $error("inject pulse too long");
   fallback_pll_a: assert property (o_clk_fallback[0] |-> o_tx_src[1:0] == 2'h2)
      else $error("fallback not on PLL");
   fallback_cause_a: assert property (o_clk_fallback[0] |-> $past(i_rec_clk_lost[0]))
      else $error("fallback without loss");
   fallback_release_a: assert property ($fell(i_rec_clk_lost[0]) |=> !o_clk_fallback[0])
      else $error("fallback held after recovery");
   align_src_a: assert property (o_frame_align[1] |-> o_tx_src[3:2] == 2'h2)
      else $error("align off PLL");
   serclk_dir_a: assert property (o_serclk_oe[1] == (o_tx_src[3:2] != 2'h1))
      else $error("serial clock direction wrong");
   src_code_a: assert property (o_tx_src[1:0] != 2'h3 && o_tx_src[3:2] != 2'h3)
      else $error("source code 11 shown");
endmodule // tcs_props

bind tcs_top tcs_props u_props (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
   .i_rec_clk_lost(i_rec_clk_lost), .o_tx_src(o_tx_src), .o_frame_align(o_frame_align),
   .o_lcv_inject(o_lcv_inject), .o_serclk_oe(o_serclk_oe), .o_clk_fallback(o_clk_fallback));

// ### tb/tcs_line_model.sv
// Purpose: Line side model that loses clock recovery
// Assumes: A loss lasts HOLD + 1 cycles after the last fail request
// Notes: Recovery returns on its own
`timescale 1ns/1ns
module tcs_line_model #(parameter HOLD = 6) (
   input wire i_clk,
   input wire [3:0] i_fail,
   output logic [3:0] o_lost = 4'h0
);
   logic [7:0] cnt_r = 8'h0;
   // Loss persists, so the block sees a level, not a glitch
   always @(posedge i_clk) begin
      if (|i_fail) begin
         o_lost <= o_lost | i_fail;
         cnt_r <= 8'(HOLD);
      end else if (cnt_r != 8'h0)
         cnt_r <= cnt_r - 8'h1;
      else
         o_lost <= 4'h0;
   end
endmodule // tcs_line_model

// ### tb/testbench.sv
// Purpose: Self-checking bench for the clock select block
// Assumes: Zero wait AHB-Lite slave
// Notes: Register values come from a fixed-seed LFSR
`timescale 1ns/1ns
module testbench;
   logic i_clk = 1'h0, rst = 1'h1, hsel = 1'h0, hwrite = 1'h0, hrdy, irq;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, lfsr = 32'h66d85eb0;
   logic [3:0] fail = 4'h0, lost, t1, algn, inj, oe, fb;
   logic [7:0] src, sh [4];
   int miscompares = 0, checked = 0, cyc = 0, c;
   tcs_top DUT (.i_clk(i_clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
      .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
      .o_hreadyout(hrdy), .o_hresp(), .i_rec_clk_lost(lost), .o_tx_src(src), .o_t1_mode(t1),
      .o_frame_align(algn), .o_lcv_inject(inj), .o_serclk_oe(oe), .o_clk_fallback(fb), .o_irq(irq));
   tcs_line_model u_line (.i_clk(i_clk), .i_fail(fail), .o_lost(lost));
   // Clock, and a ceiling that cuts a hang short
   always #4 i_clk = ~i_clk;
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         miscompares++;
         complete_run;
      end
   end
   task complete_run;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Code 11 runs from the line clock like 00
   function automatic logic [1:0] eff(input logic [7:0] d);
      return (d[1:0] == 2'h3) ? 2'h0 : d[1:0];
   endfunction
   // One single transfer; holds each phase until hready
   task bus(input logic [31:0] a, d, input logic w);
      hsel <= 1'h1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge i_clk); while (hrdy !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge i_clk); while (hrdy !== 1'h1);
      rd = hrdata;
   endtask
   // Write a channel's clock select word, check side effects, read back
   task setreg(input int n, input logic [7:0] d);
      bus(n * 32'h1000 + 32'h100, {24'h0, d}, 1'h1);
      #1;
      chk(inj, 4'(d[7] & ~sh[n][7]) << n);
      chk(t1[n], d[6]);
      sh[n] = d;
      bus(n * 32'h1000 + 32'h100, 32'h0, 1'h0);
      chk(rd & 32'h0000_00f3, {24'h0, d});
   endtask
   // Line partner loses recovery on channel 0
   task drop;
      fail <= 4'h1;
      @(posedge i_clk);
      fail <= 4'h0;
      repeat (4) @(posedge i_clk);
      #1;
   endtask
   initial begin
      repeat (2) @(posedge i_clk);
      rst <= 1'h0;
      @(posedge i_clk);
      for (c = 0; c < 4; c++) begin
         sh[c] = 8'h11;
         bus(c * 32'h1000 + 32'h100, 32'h0, 1'h0);
         chk(rd, 32'h11);
      end
      chk(src, 8'h55);
      // Random words on random channels
      for (int i = 0; i < 24; i++) begin
         lfsr = nxt(lfsr);
         c = lfsr[9:8];
         setreg(c, lfsr[7:0] & 8'hf3);
         chk(src[2 * c +: 2], eff(lfsr[7:0]));
         chk(oe[c], eff(lfsr[7:0]) != 2'h1);
      end
      // Channel 0 sync bit aligns channel 1 only under PLL
      setreg(0, 8'h30);
      setreg(1, 8'h01);
      chk(algn[1], 1'h0);
      setreg(1, 8'h02);
      chk(algn[1], 1'h1);
      setreg(0, 8'h10);
      setreg(1, 8'h22);
      chk(algn[1], 1'h0);
      // Protected loss: PLL fallback, status set, masked irq
      drop;
      chk(fb[0], 1'h1);
      chk(src[1:0], 2'h2);
      chk(irq, 1'h0);
      bus(32'hb00, 32'h0, 1'h0);
      chk(rd, 32'h20);
      bus(32'hc04, 32'h0, 1'h0);
      chk(rd, 32'ha);
      repeat (8) @(posedge i_clk);
      bus(32'hc00, 32'h20, 1'h1);
      bus(32'h200, 32'h0, 1'h0);
      chk(rd, 32'h0);
      chk(fb[0], 1'h0);
      chk(irq, 1'h1);
      bus(32'hb00, 32'h20, 1'h1);
      bus(32'hb00, 32'h0, 1'h0);
      chk(rd, 32'h0);
      chk(irq, 1'h0);
      // Unprotected loss neither falls back nor flags
      setreg(0, 8'h00);
      drop;
      chk(fb[0], 1'h0);
      bus(32'hb00, 32'h0, 1'h0);
      chk(rd, 32'h0);
      complete_run;
   end
endmodule // testbench
